// [verilog/boot_guard_pkg.sv]
// Constants for boot selection and code security logic
package boot_guard_pkg;
  // Security register location in loader flash space
  localparam logic [15:0] SEC_REG_ADDR     = 16'hffff;
  // Security register field positions
  localparam int          SEC_LOCK_BIT     = 0;
  localparam int          SEC_INHIBIT_BIT  = 1;
  localparam int          SEC_ENCRYPT_BIT  = 2;
  localparam int          SEC_OSC_GAIN_BIT = 7;
  // Erased security register value
  localparam logic [7:0]  SEC_ERASED       = 8'hff;
  // Reset values
  localparam logic [1:0]  SYNC_RESET       = 2'h0;
  localparam logic [7:0]  ID_RESET         = 8'h00;
  // Top bit of the control register readback
  localparam int          CTRL_BOOT_BIT    = 7;
  // Identification codes, values arbitrary
  localparam logic [7:0]  MAKER_ID_VALUE   = 8'h5a;
  localparam logic [7:0]  PART_ID_VALUE    = 8'h3c;
  // Power-on state sequence
  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_RUN
  } boot_state_type;
endpackage : boot_guard_pkg

// [verilog/boot_guard.sv]
// Boot source selection and code security logic
// Operation
// - Boot main flash unless loader strap present
// - Loader boot: both port-2 straps low, or override low
// - Straps sampled only at reset, then held
// - No setting register access in programming mode
// - Security bits only clear, erase-all restores
// - Security register at loader address ffff
// - Lock zero blocks flash and setting access
// - Inhibit zero: external reads see external only
// - Internal table reads reach everything always
// - Inhibit one: no table read restriction
// - Encryption on: port 0 data encoded
// - Encryption cleared only by chip erase
// - Gain select zero gives half oscillator gain
// - Identification registers fixed, not writable
// - Control top bit reports loader boot mode
`timescale 1ns/10ps
module boot_guard
  import boot_guard_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Strap pins from the board
  input  wire logic        i_boot_strap_a,
  input  wire logic        i_boot_strap_b,
  input  wire logic        i_boot_strap_override,
  // Programmer side of the security register
  input  wire logic        i_programming_mode,
  input  wire logic        i_sec_write,
  input  wire logic [15:0] i_sec_addr,
  input  wire logic        i_loader_space,
  input  wire logic [7:0]  i_sec_wdata,
  input  wire logic        i_erase_all,
  // Core access requests
  input  wire logic        i_fetch_external,
  input  wire logic        i_table_read_internal,
  input  wire logic        i_flash_access_req,
  input  wire logic        i_setting_access_req,
  input  wire logic [7:0]  i_port0_data,
  // Boot and protection results
  output logic             o_loader_boot_mode,
  output logic             o_boot_from_loader,
  output logic [7:0]       o_ctrl_readback,
  output logic [7:0]       o_security_reg,
  output logic             o_lock_active,
  output logic             o_flash_access_grant,
  output logic             o_setting_access_grant,
  output logic             o_table_read_internal_ok,
  output logic             o_encrypt_enable,
  output logic [7:0]       o_port0_out,
  output logic             o_osc_half_gain,
  output logic [7:0]       o_maker_id,
  output logic [7:0]       o_part_id
);

  // Key-scrambling function for port 0, applied only when enabled
  function automatic logic [7:0] encode_byte(input logic [7:0] d);
    encode_byte = {d[0], d[7:1]} ^ 8'ha5;
  endfunction : encode_byte

  // Reset release through two flip-flops
  logic [1:0] rst_sync_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= SYNC_RESET;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_q[1];

  // Two-stage synchronisers on the pin inputs
  logic [2:0] strap_m_q, strap_s_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_m_q <= 3'h7;
      strap_s_q <= 3'h7;
    end else begin
      strap_m_q <= {i_boot_strap_override, i_boot_strap_b, i_boot_strap_a};
      strap_s_q <= strap_m_q;
    end
  end

  // Boot state: sample once after reset release, then hold
  boot_state_type state_q, state_d;
  logic           loader_q, loader_d;
  always_comb begin
    state_d  = state_q;
    loader_d = loader_q;
    unique case (state_q)
      ST_SAMPLE: begin
        // Pin change later never alters the boot choice
        loader_d = (!strap_s_q[0] && !strap_s_q[1])
                   || !strap_s_q[2];
        state_d  = ST_RUN;
      end
      ST_RUN: begin
        loader_d = loader_q;
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_SAMPLE;
      loader_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      loader_q <= loader_d;
    end
  end

  // Security register: bits only fall; erase-all restores the erased value
  logic [7:0] sec_q, sec_d;
  logic       sec_hit;
  assign sec_hit = i_sec_write && i_loader_space
                   && (i_sec_addr == SEC_REG_ADDR);
  always_comb begin
    sec_d = sec_q;
    if (i_erase_all) begin
      sec_d = SEC_ERASED;
    end else if (sec_hit && !i_programming_mode
                 && sec_q[SEC_LOCK_BIT]) begin
      sec_d = sec_q & i_sec_wdata;
    end
  end
  // Flash-backed, so starts erased; no protection when erased
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_q <= SEC_ERASED;
    end else begin
      sec_q <= sec_d;
    end
  end

  // Registered outputs derived from the protection state
  logic       lock_d, flash_ok_d, setting_ok_d, tbl_ok_d, enc_d, half_d;
  logic [7:0] p0_d, ctrl_d;
  always_comb begin
    lock_d       = !sec_q[SEC_LOCK_BIT];
    flash_ok_d   = i_flash_access_req && !lock_d;
    setting_ok_d = i_setting_access_req && !lock_d
                   && !i_programming_mode;
    // Internal code may always read; external only if inhibit is one
    tbl_ok_d     = !i_fetch_external
                   || sec_q[SEC_INHIBIT_BIT];
    enc_d        = !sec_q[SEC_ENCRYPT_BIT];
    p0_d         = enc_d ? encode_byte(i_port0_data)
                         : i_port0_data;
    half_d       = !sec_q[SEC_OSC_GAIN_BIT];
    ctrl_d       = 8'h00;
    ctrl_d[CTRL_BOOT_BIT] = loader_q;
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_loader_boot_mode       <= 1'b0;
      o_boot_from_loader       <= 1'b0;
      o_ctrl_readback          <= 8'h00;
      o_security_reg           <= SEC_ERASED;
      o_lock_active            <= 1'b0;
      o_flash_access_grant     <= 1'b0;
      o_setting_access_grant   <= 1'b0;
      o_table_read_internal_ok <= 1'b1;
      o_encrypt_enable         <= 1'b0;
      o_port0_out              <= 8'h00;
      o_osc_half_gain          <= 1'b0;
      o_maker_id               <= ID_RESET;
      o_part_id                <= ID_RESET;
    end else begin
      o_loader_boot_mode       <= loader_q;
      o_boot_from_loader       <= loader_q;
      o_ctrl_readback          <= ctrl_d;
      o_security_reg           <= sec_q;
      o_lock_active            <= lock_d;
      o_flash_access_grant     <= flash_ok_d;
      o_setting_access_grant   <= setting_ok_d;
      o_table_read_internal_ok <= tbl_ok_d && i_table_read_internal;
      o_encrypt_enable         <= enc_d;
      o_port0_out              <= p0_d;
      o_osc_half_gain          <= half_d;
      o_maker_id               <= MAKER_ID_VALUE;
      o_part_id                <= PART_ID_VALUE;
    end
  end

  // Checks next to the logic
  a_boot_held: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q == ST_RUN |=> $stable(loader_q))
    else $error("boot mode changed after sampling");
  a_boot_strap: assert property (@(posedge i_clk) disable iff (!rst_n)
    state_q == ST_SAMPLE |=> loader_q ==
      ((!$past(strap_s_q[0]) && !$past(strap_s_q[1]))
       || !$past(strap_s_q[2])))
    else $error("boot choice does not follow straps");
  a_sec_monotone: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_erase_all |=> (sec_q & ~$past(sec_q)) == 8'h00)
    else $error("security bit rose without erase");
  a_erase_restore: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_erase_all |=> sec_q == SEC_ERASED)
    else $error("erase-all did not restore register");
  a_lock_blocks: assert property (@(posedge i_clk) disable iff (!rst_n)
    !sec_q[SEC_LOCK_BIT] |=> !o_flash_access_grant
      && !o_setting_access_grant)
    else $error("access granted while locked");
  a_prog_denied: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_programming_mode |=> !o_setting_access_grant)
    else $error("setting access in programming mode");
  a_table_ext: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_fetch_external && !sec_q[SEC_INHIBIT_BIT] |=>
      !o_table_read_internal_ok)
    else $error("external table read reached internal flash");
  a_table_int: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_fetch_external && i_table_read_internal |=>
      o_table_read_internal_ok)
    else $error("internal table read refused");
  a_osc_gain: assert property (@(posedge i_clk) disable iff (!rst_n)
    ##1 o_osc_half_gain == !$past(sec_q[SEC_OSC_GAIN_BIT]))
    else $error("oscillator gain wrong");
  a_ctrl_boot: assert property (@(posedge i_clk) disable iff (!rst_n)
    ##1 o_ctrl_readback[CTRL_BOOT_BIT] == $past(loader_q))
    else $error("control readback boot bit wrong");

endmodule : boot_guard

// [bench/strap_prog_model.sv]
// Board strap switches and flash programmer model for boot_guard
`timescale 1ns/10ps
module strap_prog_model (
  // Clock
  input  wire logic        i_clk,
  // Strap switches
  output logic             o_strap_a,
  output logic             o_strap_b,
  output logic             o_strap_ovr,
  // Programmer strobes
  output logic             o_write,
  output logic [15:0]      o_addr,
  output logic             o_space,
  output logic [7:0]       o_wdata,
  output logic             o_erase
);
  // Straps sit on pull-ups, so an open switch reads high
  initial begin
    {o_strap_ovr, o_strap_b, o_strap_a} = 3'h7;
    {o_write, o_addr, o_space, o_wdata, o_erase} = 27'h0;
  end
  // Switches stay put until the bench lets go after reset
  task automatic set_straps(input logic [2:0] s);
    @(negedge i_clk);
    {o_strap_ovr, o_strap_b, o_strap_a} = s;
  endtask : set_straps
  // One-cycle write; idle lines then show inverted junk, not old data
  task automatic write_sec(input logic [15:0] a, input logic sp,
                           input logic [7:0] d);
    @(negedge i_clk);
    {o_addr, o_space, o_wdata, o_write} = {a, sp, d, 1'b1};
    @(negedge i_clk);
    {o_addr, o_space, o_wdata, o_write} = {~a, 1'b0, ~d, 1'b0};
  endtask : write_sec
  // Whole-chip erase pulse
  task automatic erase();
    @(negedge i_clk);
    o_erase = 1'b1;
    @(negedge i_clk);
    o_erase = 1'b0;
  endtask : erase
endmodule : strap_prog_model

// [bench/boot_guard_test.sv]
// Self-checking testbench for boot_guard
`timescale 1ns/10ps
module boot_guard_test;
  import boot_guard_pkg::*;
  logic       i_clk, i_resetn, sa, sb, so, wr, sp, er;
  logic       prog, fext, tint, freq, sreq;
  logic [15:0] addr;
  logic [7:0] wd, p0d, ctrl, sec, p0o, maker, part;
  logic       lm, ldr, bl, lock, fg, sg, tok, enc, half;
  int         n_errors, n_compared;
  logic [2:0] straps [5] = '{3'h7, 3'h4, 3'h3, 3'h5, 3'h6};
  strap_prog_model u_model (.i_clk(i_clk), .o_strap_a(sa),
    .o_strap_b(sb), .o_strap_ovr(so), .o_write(wr), .o_addr(addr),
    .o_space(sp), .o_wdata(wd), .o_erase(er));
  boot_guard u_dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_boot_strap_a(sa), .i_boot_strap_b(sb),
    .i_boot_strap_override(so), .i_programming_mode(prog),
    .i_sec_write(wr), .i_sec_addr(addr), .i_loader_space(sp),
    .i_sec_wdata(wd), .i_erase_all(er), .i_fetch_external(fext),
    .i_table_read_internal(tint), .i_flash_access_req(freq),
    .i_setting_access_req(sreq), .i_port0_data(p0d),
    .o_loader_boot_mode(ldr), .o_boot_from_loader(bl),
    .o_ctrl_readback(ctrl), .o_security_reg(sec), .o_lock_active(lock),
    .o_flash_access_grant(fg), .o_setting_access_grant(sg),
    .o_table_read_internal_ok(tok), .o_encrypt_enable(enc),
    .o_port0_out(p0o), .o_osc_half_gain(half), .o_maker_id(maker),
    .o_part_id(part));
  // Free-running core clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Compare one byte-wide result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Power-on with straps held well past the synchroniser delay
  task automatic boot(input logic [2:0] s);
    u_model.set_straps(s);
    i_resetn = 1'b0;
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (6) @(negedge i_clk);
    u_model.set_straps(3'h7);
    repeat (3) @(negedge i_clk);
  endtask : boot
  // Security write, then wait out the two-edge answer
  task automatic wr_sec(input logic [15:0] a, input logic s,
                        input logic [7:0] d);
    u_model.write_sec(a, s, d);
    repeat (3) @(negedge i_clk);
  endtask : wr_sec
  // Flags packed as {lock, encrypt, half gain, flash, setting, table ok}
  function automatic logic [7:0] flags();
    return {2'h0, lock, enc, half, fg, sg, tok};
  endfunction : flags
  // Watchdog: the whole sequence needs well under the 10000-cycle limit
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
  initial begin
    {prog, fext, tint, freq, sreq} = 5'h0f;
    {n_errors, n_compared} = '0;
    p0d = 8'h3c;
    i_resetn = 1'b0;
    foreach (straps[i]) begin
      boot(straps[i]);
      lm = ~straps[i][2] | ~(straps[i][1] | straps[i][0]);
      chk({7'h0, ldr}, {7'h0, lm});
      chk({7'h0, bl}, {7'h0, lm});
      chk(ctrl, {lm, 7'h00});
    end
    chk(sec, SEC_ERASED);
    chk(flags(), 8'h07);
    chk(maker, MAKER_ID_VALUE);
    chk(part, PART_ID_VALUE);
    chk(p0o, p0d);
    wr_sec(SEC_REG_ADDR, 1'b1, 8'hfd);
    chk(flags(), 8'h06);
    fext = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(flags(), 8'h07);
    wr_sec(SEC_REG_ADDR, 1'b1, 8'hfb);
    chk(flags(), 8'h17);
    chk(p0o, {p0d[0], p0d[7:1]} ^ 8'ha5);
    wr_sec(SEC_REG_ADDR, 1'b1, 8'hff);
    chk(sec, 8'hf9);
    wr_sec(SEC_REG_ADDR, 1'b1, 8'h7f);
    chk(flags(), 8'h1f);
    wr_sec(SEC_REG_ADDR, 1'b0, 8'h00);
    wr_sec(16'hfffe, 1'b1, 8'h00);
    chk(sec, 8'h79);
    prog = 1'b1;
    wr_sec(SEC_REG_ADDR, 1'b1, 8'h00);
    chk({7'h0, sg}, 8'h00);
    chk(sec, 8'h79);
    prog = 1'b0;
    wr_sec(SEC_REG_ADDR, 1'b1, 8'hfe);
    chk(flags(), 8'h39);
    wr_sec(SEC_REG_ADDR, 1'b1, 8'h00);
    chk(sec, 8'h78);
    u_model.erase();
    repeat (3) @(negedge i_clk);
    chk(sec, SEC_ERASED);
    chk(flags(), 8'h07);
    // Dropped requests must leave every grant low, even when unlocked
    {tint, freq, sreq} = 3'h0;
    repeat (2) @(negedge i_clk);
    chk(flags(), 8'h00);
    end_sim();
  end
endmodule : boot_guard_test
